// ==== verilog/pdio_pkg.sv ====
// Purpose: Shared constants and types of the discrete PLC handshake block
// Assumes: CLK_SYS at 125 MHz, time base of one millisecond tick
// Notes:   Register offsets are byte addresses on the plain register port
package pdio_pkg;

	localparam int unsigned CLK_FREQ_HZ      = 125_000_000;
	localparam int unsigned TICK_TIME_US     = 1000;
	localparam int unsigned TICK_CYCLES      =
		(CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
	// Debounce measured in ms ticks; long enough for relay contacts
	localparam int unsigned DEBOUNCE_TIME_MS = 10;
	localparam int unsigned DEBOUNCE_TICKS   =
		(DEBOUNCE_TIME_MS * 1000) / TICK_TIME_US;
	// Recommended run/stop pulse width, informative only
	localparam int unsigned RUN_PULSE_TIME_MS = 500;

	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] ADDR_CTRL    = 5'h00;
	localparam logic [4:0] ADDR_CONFIG  = 5'h04;
	localparam logic [4:0] ADDR_ACT_MAP = 5'h08;
	localparam logic [4:0] ADDR_TARGET  = 5'h0c;
	localparam logic [4:0] ADDR_PULSE   = 5'h10;
	localparam logic [4:0] ADDR_STATUS  = 5'h14;
	localparam logic [4:0] ADDR_COUNT   = 5'h18;

	// CTRL fields
	localparam int unsigned CTRL_BOOT_BIT  = 0;
	localparam int unsigned CTRL_WARN_BIT  = 1;
	localparam int unsigned CTRL_CLEAR_BIT = 2;
	// CONFIG fields
	localparam int unsigned CFG_WARN_BIT   = 0;
	localparam int unsigned CFG_BUF2_BIT   = 1;
	localparam int unsigned CFG_EXTS_BIT   = 2;
	localparam int unsigned CFG_FAULT_BIT  = 3;
	localparam int unsigned CFG_COUNT_BIT  = 4;

	localparam logic [4:0]  CONFIG_RESET   = 5'h00;
	// Good -> actuator 3, defective -> 2, surplus -> 1 (indices 2,1,0)
	localparam logic [5:0]  ACT_MAP_RESET  = 6'h06;
	localparam logic [15:0] TARGET_RESET   = 16'h0000;
	localparam logic [7:0]  PULSE_RESET    = 8'h14;

	typedef enum logic [1:0] {
		ST_STOP  = 2'b00,
		ST_RUN   = 2'b01,
		ST_ERROR = 2'b10
	} pdio_run_state_type;

	typedef enum logic [1:0] {
		CLS_GOOD    = 2'b00,
		CLS_DEFECT  = 2'b01,
		CLS_SURPLUS = 2'b10
	} pdio_class_type;

endpackage

// ==== verilog/pdio_tick.sv ====
// Purpose: Divider making a one-cycle millisecond enable
// Assumes: Single clock domain
// Notes:   CYCLES is a parameter so simulation can shorten it
`timescale 1ns/100ps
module pdio_tick
	import pdio_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYCLES
)
(
	input  wire logic clk,
	input  wire logic arst_n,
	output logic      tick
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} pdio_tick_state_type;

	pdio_tick_state_type st_r;
	pdio_tick_state_type st_nxt;

	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt >= 32'(CYCLES - 1))
		begin
			st_nxt.cnt  = 32'h0000_0000;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;

	assign tick = st_r.tick;

endmodule // pdio_tick

// ==== verilog/pdio_in_filter.sv ====
// Purpose: Three-stage synchroniser and tick-based debounce per input
// Assumes: tick is a one-cycle enable on the same clock
// Notes:   Output changes after input is stable for DEB_TICKS ticks
`timescale 1ns/100ps
module pdio_in_filter
	import pdio_pkg::*;
#(
	parameter int unsigned W         = 1,
	parameter int unsigned DEB_TICKS = DEBOUNCE_TICKS
)
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         tick,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] clean
);

	typedef struct packed {
		logic [W-1:0]       s1;
		logic [W-1:0]       s2;
		logic [W-1:0]       s3;
		logic [W-1:0][7:0]  cnt;
		logic [W-1:0]       clean;
	} pdio_filt_state_type;

	pdio_filt_state_type st_r;
	pdio_filt_state_type st_nxt;

	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++)
		begin
			// Only second and third stage are compared; first stays private
			if (st_r.s2[i] != st_r.s3[i] || st_r.s3[i] == st_r.clean[i])
				st_nxt.cnt[i] = 8'h00;
			else if (st_r.cnt[i] >= 8'(DEB_TICKS))
			begin
				st_nxt.clean[i] = st_r.s3[i];
				st_nxt.cnt[i]   = 8'h00;
			end
			else if (tick)
				st_nxt.cnt[i] = st_r.cnt[i] + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;

	assign clean = st_r.clean;

endmodule // pdio_in_filter

// ==== verilog/pdio_ctrl.sv ====
// Purpose: Run/stop handshake, part sorting, feeder and fault outputs
// Assumes: Pins are asynchronous; part events come from the same clock
// Notes:   Configuration and status live on a plain register port
`timescale 1ns/100ps
module pdio_ctrl
	import pdio_pkg::*;
#(
	parameter int unsigned TICK_CYC  = TICK_CYCLES,
	parameter int unsigned DEB_TICKS = DEBOUNCE_TICKS,
	parameter int unsigned CNT_W     = 16
)
(
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	input  wire logic [4:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        RUN_STOP_IN,
	input  wire logic        PANEL_BUTTON,
	input  wire logic [3:0]  PROG_SEL,
	input  wire logic        PANEL_LOCK,
	input  wire logic        BUF1_SENSOR,
	input  wire logic        EXT_FAULT,
	input  wire logic        COUNT_RESTART,
	input  wire logic        PART_VALID,
	input  wire logic [1:0]  PART_CLASS,
	output logic             BOOT_DONE,
	output logic             RUN_STATUS,
	output logic      [3:0]  PROG_ACTIVE,
	output logic      [2:0]  ACTUATOR,
	output logic             ACT4_TARGET,
	output logic             FEEDER_ON,
	output logic             FAULT_ERROR,
	output logic             FAULT_WARN
);

	localparam int unsigned NIN = 10;

	typedef struct packed {
		pdio_run_state_type run_state;
		logic               boot;
		logic               warn_req;
		logic [4:0]         cfg;
		logic [5:0]         act_map;
		logic [CNT_W-1:0]   target;
		logic [7:0]         pulse;
		logic [CNT_W-1:0]   count;
		logic               target_hit;
		logic               feeder;
		logic [3:0]         prog;
		logic [3:0][7:0]    act_cnt;
		logic [3:0]         act;
		logic               rs_prev;
		logic               btn_prev;
		logic               rst_prev;
		logic [31:0]        rdata;
		logic               run_o;
		logic               act4_o;
		logic               err_o;
		logic               warn_o;
	} pdio_ctrl_state_type;

	pdio_ctrl_state_type st_r;
	pdio_ctrl_state_type st_nxt;

	logic           tick;
	logic [NIN-1:0] pins_raw;
	logic [NIN-1:0] pins;
	logic           rs_f;
	logic           btn_f;
	logic [3:0]     sel_f;
	logic           lock_f;
	logic           buf1_f;
	logic           fault_f;
	logic           restart_f;

	// Actuator index for a part class from the allocation map
	function automatic logic [1:0] act_index(input logic [5:0] map,
		input pdio_class_type cls);
		logic [1:0] idx;
		idx = 2'h0;
		unique case (cls)
			CLS_GOOD:    idx = map[1:0];
			CLS_DEFECT:  idx = map[3:2];
			CLS_SURPLUS: idx = map[5:4];
			default:     idx = map[3:2];
		endcase
		return idx;
	endfunction

	pdio_tick #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.clk    (CLK_SYS),
		.arst_n (ARST_N),
		.tick   (tick)
	);

	assign pins_raw = {RUN_STOP_IN, PANEL_BUTTON, PROG_SEL, PANEL_LOCK,
		BUF1_SENSOR, EXT_FAULT, COUNT_RESTART};

	pdio_in_filter #(
		.W         (NIN),
		.DEB_TICKS (DEB_TICKS)
	) u_filter (
		.clk    (CLK_SYS),
		.arst_n (ARST_N),
		.tick   (tick),
		.raw    (pins_raw),
		.clean  (pins)
	);

	assign rs_f      = pins[9];
	assign btn_f     = pins[8];
	assign sel_f     = pins[7:4];
	assign lock_f    = pins[3];
	assign buf1_f    = pins[2];
	assign fault_f   = pins[1];
	assign restart_f = pins[0];

	always_comb
	begin
		logic           toggle;
		logic           fault_act;
		logic           count_on;
		logic           buf2_on;
		logic           exts_on;
		logic           err_clear;
		logic           restart;
		logic [3:0]     code;
		pdio_class_type cls;
		logic [1:0]     idx;
		logic [4:0]     cfg_w;

		toggle    = 1'b0;
		fault_act = 1'b0;
		count_on  = 1'b0;
		buf2_on   = 1'b0;
		exts_on   = 1'b0;
		err_clear = 1'b0;
		restart   = 1'b0;
		code      = 4'h0;
		cls       = CLS_DEFECT;
		idx       = 2'h0;
		cfg_w     = 5'h00;

		st_nxt          = st_r;
		st_nxt.rdata    = 32'h0000_0000;
		st_nxt.rs_prev  = rs_f;
		st_nxt.btn_prev = btn_f;
		st_nxt.rst_prev = restart_f;

		count_on  = st_r.cfg[CFG_COUNT_BIT];
		buf2_on   = st_r.cfg[CFG_BUF2_BIT];
		exts_on   = st_r.cfg[CFG_EXTS_BIT];
		// Trailing edge marks a complete pulse
		toggle    = (st_r.rs_prev & ~rs_f) |
			(st_r.btn_prev & ~btn_f & ~lock_f);
		fault_act = st_r.cfg[CFG_FAULT_BIT] & fault_f;
		restart   = ~st_r.rst_prev & restart_f;

		// Shared pins are masked out of the select code when reused
		code      = sel_f;
		if (buf2_on)
			code[2] = 1'b0;
		if (exts_on)
			code[3] = 1'b0;

		// Register writes
		if (WR)
		begin
			unique case (ADDR)
				ADDR_CTRL:
				begin
					st_nxt.boot     = WDATA[CTRL_BOOT_BIT];
					st_nxt.warn_req = WDATA[CTRL_WARN_BIT];
					err_clear       = WDATA[CTRL_CLEAR_BIT];
				end
				ADDR_CONFIG:
				begin
					cfg_w = WDATA[4:0];
					// External sensor takes precedence over counting
					if (cfg_w[CFG_EXTS_BIT])
						cfg_w[CFG_COUNT_BIT] = 1'b0;
					st_nxt.cfg = cfg_w;
				end
				ADDR_ACT_MAP: st_nxt.act_map = WDATA[5:0];
				ADDR_TARGET:  st_nxt.target  = WDATA[CNT_W-1:0];
				ADDR_PULSE:   st_nxt.pulse   = WDATA[7:0];
				default:      ;
			endcase
		end

		// Run state; a fault present in the clear cycle keeps the error
		unique case (st_r.run_state)
			ST_STOP:
				if (fault_act)
					st_nxt.run_state = ST_ERROR;
				else if (toggle && st_r.boot)
				begin
					st_nxt.run_state = ST_RUN;
					st_nxt.prog      = code;
				end
			ST_RUN:
				if (fault_act)
					st_nxt.run_state = ST_ERROR;
				else if (toggle)
					st_nxt.run_state = ST_STOP;
			ST_ERROR:
				if (err_clear && !fault_act)
					st_nxt.run_state = ST_STOP;
			default:
				st_nxt.run_state = ST_STOP;
		endcase

		// Count and target flag clear on leaving run, on disabling counting or on a restart edge
		if (st_r.run_state != ST_RUN || !count_on || restart)
		begin
			st_nxt.count      = '0;
			st_nxt.target_hit = 1'b0;
		end
		else if (PART_VALID)
		begin
			cls = pdio_class_type'(PART_CLASS);
			if (cls == CLS_GOOD && st_r.target_hit)
				cls = CLS_SURPLUS;
		end

		// Part sorting while running
		if (st_r.run_state == ST_RUN && PART_VALID)
		begin
			if (!(count_on && !restart))
				cls = pdio_class_type'(PART_CLASS);
			// Downstream check only touches parts already judged good
			if (exts_on && cls == CLS_GOOD && !sel_f[3])
				cls = CLS_DEFECT;
			if (count_on && !restart && cls == CLS_GOOD)
			begin
				st_nxt.count = st_r.count + 1'b1;
				if (st_r.count + 1'b1 >= st_r.target)
					st_nxt.target_hit = 1'b1;
			end
			idx = act_index(st_r.act_map, cls);
			st_nxt.act_cnt[idx] = st_r.pulse;
		end

		for (int i = 0; i < 4; i++)
		begin
			if (tick && st_r.act_cnt[i] != 8'h00 &&
				st_nxt.act_cnt[i] == st_r.act_cnt[i])
				st_nxt.act_cnt[i] = st_r.act_cnt[i] - 8'h01;
			st_nxt.act[i] = st_nxt.act_cnt[i] != 8'h00;
		end

		// Feeder runs only while the unit runs
		if (st_nxt.run_state != ST_RUN)
			st_nxt.feeder = 1'b0;
		else if (buf2_on)
		begin
			// Start on low level empty, stop on high level full
			if (!buf1_f)
				st_nxt.feeder = 1'b1;
			else if (sel_f[2])
				st_nxt.feeder = 1'b0;
		end
		else
			st_nxt.feeder = ~buf1_f;
		// Pins come straight from flops; shared pin shows target when counting
		st_nxt.run_o  = st_nxt.run_state == ST_RUN;
		st_nxt.act4_o = st_nxt.cfg[CFG_COUNT_BIT] ? st_nxt.target_hit :
			st_nxt.act[3];
		st_nxt.err_o  = st_nxt.run_state == ST_ERROR;
		st_nxt.warn_o = st_nxt.cfg[CFG_WARN_BIT] & st_nxt.warn_req;

		// Register reads, data in the following cycle
		if (RD)
		begin
			unique case (ADDR)
				ADDR_CTRL:    st_nxt.rdata = {29'h0, 1'b0,
					st_r.warn_req, st_r.boot};
				ADDR_CONFIG:  st_nxt.rdata = {27'h0, st_r.cfg};
				ADDR_ACT_MAP: st_nxt.rdata = {26'h0, st_r.act_map};
				ADDR_TARGET:  st_nxt.rdata = 32'(st_r.target);
				ADDR_PULSE:   st_nxt.rdata = {24'h0, st_r.pulse};
				ADDR_STATUS:  st_nxt.rdata = {16'h0, sel_f, st_r.prog,
					1'b0, fault_f, buf1_f, st_r.feeder,
					st_r.target_hit, st_r.run_state, st_r.boot};
				ADDR_COUNT:   st_nxt.rdata = 32'(st_r.count);
				default:      st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
		if (!ARST_N)
		begin
			st_r           <= '0;
			st_r.run_state <= ST_STOP;
			st_r.cfg       <= CONFIG_RESET;
			st_r.act_map   <= ACT_MAP_RESET;
			st_r.target    <= CNT_W'(TARGET_RESET);
			st_r.pulse     <= PULSE_RESET;
		end
		else
			st_r <= st_nxt;

	assign RDATA       = st_r.rdata;
	assign BOOT_DONE   = st_r.boot;
	assign RUN_STATUS  = st_r.run_o;
	assign PROG_ACTIVE = st_r.prog;
	assign ACTUATOR    = st_r.act[2:0];
	assign ACT4_TARGET = st_r.act4_o;
	assign FEEDER_ON   = st_r.feeder;
	assign FAULT_ERROR = st_r.err_o;
	assign FAULT_WARN  = st_r.warn_o;

endmodule // pdio_ctrl

// ==== sim/pdio_checker.sv ====
// Purpose: Port assertions for pdio_ctrl
// Assumes: One clock domain, ARST_N async active low
// Notes:   Filter delays are bounded loosely, actuator response within 1 to 4 cycles
`timescale 1ns/100ps
module pdio_checker
(
	input wire logic        CLK_SYS,
	input wire logic        ARST_N,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        EXT_FAULT,
	input wire logic        PART_VALID,
	input wire logic        BOOT_DONE,
	input wire logic        RUN_STATUS,
	input wire logic [3:0]  PROG_ACTIVE,
	input wire logic [2:0]  ACTUATOR,
	input wire logic        ACT4_TARGET,
	input wire logic        FEEDER_ON,
	input wire logic        FAULT_ERROR,
	input wire logic        FAULT_WARN
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
	property p_err_stop; FAULT_ERROR |-> !RUN_STATUS; endproperty
	property p_run_boot; $rose(RUN_STATUS) |-> BOOT_DONE; endproperty
	property p_prog_hold;
		RUN_STATUS && $past(RUN_STATUS) |-> $stable(PROG_ACTIVE);
	endproperty
	property p_feed_off; !RUN_STATUS ##1 !RUN_STATUS |-> !FEEDER_ON;
	endproperty
	property p_part_act;
		RUN_STATUS && PART_VALID |-> ##[1:4] (ACTUATOR != 3'h0 || ACT4_TARGET);
	endproperty
	property p_warn_src; $rose(FAULT_WARN) |-> $past(WR) || $past(WR, 2);
	endproperty
	property p_err_src; $rose(FAULT_ERROR) |-> $past(EXT_FAULT, 4);
	endproperty
	property p_boot_src; $changed(BOOT_DONE) |-> $past(WR) || $past(WR, 2);
	endproperty
	a_rd_idle:
		assert property (p_rd_idle) else $error("read data not idle");
	a_err_stop:
		assert property (p_err_stop) else $error("running in error");
	a_run_boot:
		assert property (p_run_boot) else $error("start before boot");
	a_prog_hold:
		assert property (p_prog_hold) else $error("program changed in run");
	a_feed_off:
		assert property (p_feed_off) else $error("feeder on while stopped");
	a_part_act:
		assert property (p_part_act) else $error("part without actuator");
	a_warn_src:
		assert property (p_warn_src) else $error("warning without write");
	a_err_src:
		assert property (p_err_src) else $error("error without fault pin");
	a_boot_src:
		assert property (p_boot_src) else $error("boot flag without write");
	c_run: cover property ($rose(RUN_STATUS));
	c_err: cover property ($rose(FAULT_ERROR));
	c_act: cover property (ACTUATOR != 3'h0);
endmodule // pdio_checker

bind pdio_ctrl pdio_checker pdio_checker_i (.CLK_SYS, .ARST_N, .WR, .RD,
	.RDATA, .EXT_FAULT, .PART_VALID, .BOOT_DONE, .RUN_STATUS, .PROG_ACTIVE,
	.ACTUATOR, .ACT4_TARGET, .FEEDER_ON, .FAULT_ERROR, .FAULT_WARN);

// ==== sim/pdio_plc.sv ====
// Purpose: Controller model driving run/stop pulses and program select
// Assumes: Same clock as the unit
// Notes:   early skips the boot wait so a refusal can be provoked
`timescale 1ns/100ps
module pdio_plc
(
	input wire logic  clk,
	input wire logic  boot_done,
	output logic       run_stop,
	output logic [3:0] prog_sel
);
	initial
	begin
		run_stop = 1'b0;
		prog_sel = 4'h0;
	end
	task automatic pulse(input int hi, input logic [3:0] sel, input bit early);
		int n;
		n = 0;
		while (!early && boot_done !== 1'b1 && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		prog_sel <= sel;
		repeat (40) @(posedge clk);
		run_stop <= 1'b1;
		repeat (hi) @(posedge clk);
		run_stop <= 1'b0;
		repeat (60) @(posedge clk);
	endtask
	// Drives all four select pins; callers pass sel so that the program bits stay put
	task automatic set_sel(input logic [3:0] sel);
		@(posedge clk);
		prog_sel <= sel;
	endtask
endmodule // pdio_plc

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for pdio_ctrl
// Assumes: Shortened tick of 10 cycles and debounce of 2 ticks
// Notes:   Reused select pins are set while their function is on and later set back to the program code
`timescale 1ns/100ps
module tb_top
	import pdio_pkg::*;
;
	logic        CLK_SYS = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0;
	logic        PANEL_BUTTON = 1'b0, PANEL_LOCK = 1'b0, BUF1_SENSOR = 1'b0;
	logic        EXT_FAULT = 1'b0, COUNT_RESTART = 1'b0, PART_VALID = 1'b0;
	logic [1:0]  PART_CLASS = 2'h0;
	logic [4:0]  ADDR = 5'h00;
	logic [31:0] WDATA = 32'h0, RDATA, d;
	logic [3:0]  PROG_SEL, PROG_ACTIVE, sel;
	logic [2:0]  ACTUATOR;
	logic        RUN_STOP_IN, BOOT_DONE, RUN_STATUS, ACT4_TARGET;
	logic        FEEDER_ON, FAULT_ERROR, FAULT_WARN;
	int          mismatches = 0, tests_run = 0, seed = 32'hce7b3273;

	always #4 CLK_SYS = ~CLK_SYS;

	pdio_ctrl #(.TICK_CYC(10), .DEB_TICKS(2)) pdio_ctrl_i (.CLK_SYS, .ARST_N,
		.ADDR, .WDATA, .WR, .RD, .RDATA, .RUN_STOP_IN, .PANEL_BUTTON,
		.PROG_SEL, .PANEL_LOCK, .BUF1_SENSOR, .EXT_FAULT, .COUNT_RESTART,
		.PART_VALID, .PART_CLASS, .BOOT_DONE, .RUN_STATUS, .PROG_ACTIVE,
		.ACTUATOR, .ACT4_TARGET, .FEEDER_ON, .FAULT_ERROR, .FAULT_WARN);
	pdio_plc pdio_plc_i (.clk(CLK_SYS), .boot_done(BOOT_DONE),
		.run_stop(RUN_STOP_IN), .prog_sel(PROG_SEL));

	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [4:0] a,
		input logic [31:0] e);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1 chk(nm, RDATA, e);
	endtask
	// Waits first so the previous actuator pulse has ended
	task automatic part(input logic [1:0] c, input logic [2:0] e);
		cyc(30);
		PART_VALID <= 1'b1;
		PART_CLASS <= c;
		@(posedge CLK_SYS);
		PART_VALID <= 1'b0;
		cyc(3);
		#1 chk("actuator", 32'(ACTUATOR), 32'(e));
	endtask
	task automatic btn;
		@(posedge CLK_SYS);
		PANEL_BUTTON <= 1'b1;
		cyc(60);
		PANEL_BUTTON <= 1'b0;
		cyc(60);
	endtask
	function automatic logic [2:0] exp_act(input logic [1:0] c);
		return (c == 2'h0) ? 3'h4 : (c == 2'h1) ? 3'h2 : 3'h1;
	endfunction

	initial
	begin
		cyc(12);
		ARST_N <= 1'b1;
		rdc("config", ADDR_CONFIG, 32'h0);
		rdc("act_map", ADDR_ACT_MAP, 32'h6);
		rdc("unmapped", 5'h1c, 32'h0);
		pdio_plc_i.pulse(60, 4'h0, 1'b1);
		chk("run_early", 32'(RUN_STATUS), 32'h0);
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		chk("boot", 32'(BOOT_DONE), 32'h1);
		pdio_plc_i.pulse(5, 4'h0, 1'b0);
		chk("run_short", 32'(RUN_STATUS), 32'h0);
		sel = 4'($random(seed));
		pdio_plc_i.pulse(60, sel, 1'b0);
		chk("run", 32'(RUN_STATUS), 32'h1);
		chk("prog", 32'(PROG_ACTIVE), 32'(sel));
		rdc("status", ADDR_STATUS, {16'h0, sel, sel, 8'h13});
		repeat (3)
		begin
			BUF1_SENSOR <= 1'($random(seed));
			cyc(50);
			chk("feeder", 32'(FEEDER_ON), 32'(!BUF1_SENSOR));
		end
		wr(ADDR_CONFIG, 32'h2);
		BUF1_SENSOR <= 1'b0;
		pdio_plc_i.set_sel(sel & 4'hb);
		cyc(50);
		chk("feed_low", 32'(FEEDER_ON), 32'h1);
		BUF1_SENSOR <= 1'b1;
		cyc(50);
		chk("feed_hold", 32'(FEEDER_ON), 32'h1);
		pdio_plc_i.set_sel(sel | 4'h4);
		cyc(50);
		chk("feed_full", 32'(FEEDER_ON), 32'h0);
		pdio_plc_i.set_sel(sel & 4'hb);
		cyc(50);
		chk("feed_held", 32'(FEEDER_ON), 32'h0);
		wr(ADDR_PULSE, 32'h2);
		repeat (6)
		begin
			d = 32'($unsigned($random(seed)) % 3);
			part(d[1:0], exp_act(d[1:0]));
		end
		wr(ADDR_ACT_MAP, 32'h7);
		part(2'h0, 3'h0);
		chk("act4", 32'(ACT4_TARGET), 32'h1);
		wr(ADDR_ACT_MAP, 32'h6);
		wr(ADDR_CONFIG, 32'h4);
		pdio_plc_i.set_sel(sel & 4'h7);
		part(2'h0, 3'h2);
		pdio_plc_i.set_sel(sel | 4'h8);
		part(2'h0, 3'h4);
		part(2'h1, 3'h2);
		wr(ADDR_CONFIG, 32'h10);
		wr(ADDR_TARGET, 32'h2);
		part(2'h0, 3'h4);
		part(2'h0, 3'h4);
		chk("target", 32'(ACT4_TARGET), 32'h1);
		rdc("count", ADDR_COUNT, 32'h2);
		part(2'h0, 3'h1);
		COUNT_RESTART <= 1'b1;
		cyc(40);
		chk("target_rst", 32'(ACT4_TARGET), 32'h0);
		COUNT_RESTART <= 1'b0;
		part(2'h0, 3'h4);
		rdc("count_rst", ADDR_COUNT, 32'h1);
		PANEL_LOCK <= 1'b1;
		cyc(40);
		btn();
		chk("run_locked", 32'(RUN_STATUS), 32'h1);
		PANEL_LOCK <= 1'b0;
		cyc(40);
		btn();
		chk("run_panel", 32'(RUN_STATUS), 32'h0);
		rdc("count_stop", ADDR_COUNT, 32'h0);
		wr(ADDR_CONFIG, 32'h14);
		rdc("config_excl", ADDR_CONFIG, 32'h4);
		wr(ADDR_CONFIG, 32'h1);
		wr(ADDR_CTRL, 32'h3);
		cyc(4);
		chk("warn", 32'(FAULT_WARN), 32'h1);
		wr(ADDR_CONFIG, 32'h8);
		pdio_plc_i.pulse(60, sel, 1'b0);
		EXT_FAULT <= 1'b1;
		cyc(50);
		chk("error", 32'(FAULT_ERROR), 32'h1);
		chk("run_err", 32'(RUN_STATUS), 32'h0);
		EXT_FAULT <= 1'b0;
		cyc(50);
		wr(ADDR_CTRL, 32'h5);
		cyc(4);
		chk("error_clr", 32'(FAULT_ERROR), 32'h0);
		pdio_plc_i.pulse(60, sel, 1'b0);
		chk("run_again", 32'(RUN_STATUS), 32'h1);
		pdio_plc_i.pulse(60, sel, 1'b0);
		chk("run_stop", 32'(RUN_STATUS), 32'h0);
		final_report();
	end

	initial
	begin
		cyc(20000);
		mismatches++;
		final_report();
	end
endmodule // tb_top
